// ---- pvs_vout_status.sv ----
`timescale 1ns/1ps
module pvs_vout_status #(
  parameter int CH_NUM = pvs_pkg::CH_NUM  // Number of paged channels
) (
  input  wire logic                                   clock_i,           // System clock
  input  wire logic                                   rst_b_i,           // Async reset, low
  input  wire pvs_pkg::pvs_req_t                      req_i,             // Decoded command
  output pvs_pkg::pvs_rsp_t                           rsp_o,             // Command answer
  input  wire pvs_pkg::pvs_fault_t [CH_NUM-1:0]       fault_i,           // Output detectors
  input  wire pvs_pkg::pvs_detail_t [CH_NUM-1:0]      detail_i,          // Other status bytes
  input  wire logic                                   input_undervolt_i, // Shared lockout flag
  input  wire logic                                   cml_detail_i,      // Shared COMM_MEMORY_LOGIC_SUMMARY flag
  output logic [7:0]                                  page_o,            // Current selector
  output logic [CH_NUM-1:0][7:0]                      vout_status_o,     // Status bytes
  output logic [CH_NUM-1:0][15:0]                     summary_o          // Summary words
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  page;                     // Channel selector
  logic [7:0]  vout_flags [CH_NUM];      // Latched voltage flags per channel
  pvs_pkg::pvs_rsp_t rsp;                // Registered answer
  logic [15:0] next_rd_data;             // Read data for the current request

  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  wire page_is_a   = (page == pvs_pkg::PAGE_A);    // Channel A alone
  wire page_is_b   = (page == pvs_pkg::PAGE_B);    // Channel B alone
  wire page_is_all = (page == pvs_pkg::PAGE_ALL);  // Broadcast selector
  wire page_ok     = page_is_a | page_is_b | page_is_all;
  // Broadcast reads show channel A
  wire rd_ch       = page_is_b;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire is_byte    = (req_i.prot == pvs_pkg::PVS_PROT_BYTE);
  wire is_word    = (req_i.prot == pvs_pkg::PVS_PROT_WORD);
  wire hit_vout   = req_i.valid & (req_i.cmd == pvs_pkg::CMD_VOUT);
  wire hit_sum    = req_i.valid & (req_i.cmd == pvs_pkg::CMD_SUMMARY);
  wire hit_page   = req_i.valid & (req_i.cmd == pvs_pkg::CMD_PAGE);
  // Only byte transactions reach the voltage status byte
  wire vout_rd    = hit_vout & ~req_i.write & is_byte & page_ok;
  wire vout_wr    = hit_vout &  req_i.write & is_byte & page_ok;
  // The summary word only answers a word read; any write falls out
  wire sum_rd     = hit_sum & ~req_i.write & is_word & page_ok;
  // Selector accepts only the three defined values
  wire page_val   = (req_i.data[7:0] == pvs_pkg::PAGE_A) |
                    (req_i.data[7:0] == pvs_pkg::PAGE_B) |
                    (req_i.data[7:0] == pvs_pkg::PAGE_ALL);
  wire page_wr    = hit_page & req_i.write & is_byte & page_val;
  wire page_rd    = hit_page & ~req_i.write & is_byte;
  wire accepted   = vout_rd | vout_wr | sum_rd | page_wr | page_rd;
  // Anything not accepted is rejected and touches no state
  wire rejected   = req_i.valid & ~accepted;

  // Only supported bits can be cleared; zeros keep their flag
  wire [7:0] clr_bits = req_i.data[7:0] & pvs_pkg::VOUT_SUP_MASK;

  // ----------------------------------------------------------------
  // Selector register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      page <= pvs_pkg::PAGE_RESET;
    end else if (page_wr) begin
      page <= req_i.data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-channel voltage flags and summary words
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH_NUM; g++) begin : g_ch
      logic [7:0] set_bits;   // Detector events this cycle
      logic [7:0] clr_mask;   // Host clear for this channel
      logic [7:0] next_flags; // Flag value for the next edge
      logic       ch_sel;     // Channel addressed by the selector
      logic       any_vout;   // Any voltage flag standing

      // Broadcast writes clear both channels at once
      assign ch_sel = page_is_all | (page == 8'(g));

      // Place each detector on its bit, unsupported ones stay zero
      always_comb begin
        set_bits                             = 8'h00;
        set_bits[pvs_pkg::OUTPUT_OVERVOLTAGE_FAULT_FLAG_BIT]      = fault_i[g].ovf;
        set_bits[pvs_pkg::OUTPUT_UNDERVOLTAGE_FAULT_FLAG_BIT]      = fault_i[g].uvf;
        set_bits[pvs_pkg::VOUT_LIMIT_BIT]    = fault_i[g].limit;
      end

      assign clr_mask = (vout_wr & ch_sel) ? clr_bits : 8'h00;

      // A detection in the clearing cycle wins, so no event is lost
      // and a standing fault keeps its flag set through a clear
      assign next_flags = ((vout_flags[g] & ~clr_mask) | set_bits)
                          & pvs_pkg::VOUT_SUP_MASK;

      // Latch the flags; masking keeps the unused bits at zero
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          vout_flags[g] <= pvs_pkg::VOUT_RESET;
        end else begin
          vout_flags[g] <= next_flags;
        end
      end

      assign vout_status_o[g] = vout_flags[g];
      assign any_vout         = |vout_flags[g];

      // Summary word is pure wiring of detail flags: clearing a
      // detail bit drops its summary bit in the same cycle
      always_comb begin
        summary_o[g]                           = 16'h0000;
        summary_o[g][pvs_pkg::SUM_VOUT_BIT]    = any_vout;
        summary_o[g][pvs_pkg::SUM_VOUT_OV_BIT] =
          vout_flags[g][pvs_pkg::OUTPUT_OVERVOLTAGE_FAULT_FLAG_BIT];
        summary_o[g][pvs_pkg::SUM_OUTPUT_OVERCURRENT_SUMMARY_BIT] = detail_i[g].oc;
        summary_o[g][pvs_pkg::SUM_INPUT_UNDERVOLT_SUMMARY_BIT]  = input_undervolt_i;
        summary_o[g][pvs_pkg::SUM_TEMP_BIT]    = detail_i[g].temp;
        summary_o[g][pvs_pkg::SUM_CML_BIT]     = cml_detail_i;
        // Undervoltage and the other detail flags fall here
        summary_o[g][pvs_pkg::SUM_OTHER_BIT]   =
          vout_flags[g][pvs_pkg::OUTPUT_UNDERVOLTAGE_FAULT_FLAG_BIT] | detail_i[g].other;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Reads show the flags as they stand before this cycle's update
  always_comb begin
    next_rd_data = 16'h0000;
    if (vout_rd) begin
      next_rd_data = {8'h00, vout_flags[rd_ch]};
    end else if (sum_rd) begin
      next_rd_data = summary_o[rd_ch];
    end else if (page_rd) begin
      next_rd_data = {8'h00, page};
    end
  end

  // ----------------------------------------------------------------
  // Answer register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp <= '0;
    end else begin
      rsp.done   <= req_i.valid;
      rsp.reject <= rejected;
      // Data holds until the next completed transaction
      if (req_i.valid) begin
        rsp.data <= next_rd_data;
      end
    end
  end

  assign rsp_o  = rsp;
  assign page_o = page;

endmodule // pvs_vout_status

// ---- pvs_pkg.sv ----
package pvs_pkg;

  // ----------------------------------------------------------------
  // Channel count and command codes
  // ----------------------------------------------------------------
  localparam int         CH_NUM      = 2;      // Channels A and B
  localparam logic [7:0] CMD_PAGE    = 8'h00;  // Channel selector command
  localparam logic [7:0] CMD_SUMMARY = 8'h79;  // Summary status word, read word only
  localparam logic [7:0] CMD_VOUT    = 8'h7a;  // Output voltage status byte

  // ----------------------------------------------------------------
  // Channel selector values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_A     = 8'h00;   // Channel A
  localparam logic [7:0] PAGE_B     = 8'h01;   // Channel B
  localparam logic [7:0] PAGE_ALL   = 8'hff;   // Both channels, reads show A
  localparam logic [7:0] PAGE_RESET = 8'h00;   // Selector after reset

  // ----------------------------------------------------------------
  // Output voltage status byte layout
  // ----------------------------------------------------------------
  localparam int         OUTPUT_OVERVOLTAGE_FAULT_FLAG_BIT   = 7;      // Overvoltage fault
  localparam int         OUTPUT_UNDERVOLTAGE_FAULT_FLAG_BIT   = 4;      // Undervoltage fault
  localparam int         VOUT_LIMIT_BIT = 3;      // Programmed value out of limits
  localparam logic [7:0] VOUT_SUP_MASK  = 8'h98;  // Bits that exist
  localparam logic [7:0] VOUT_RESET     = 8'h00;  // Flags after reset

  // ----------------------------------------------------------------
  // Summary status word layout
  // ----------------------------------------------------------------
  localparam int SUM_VOUT_BIT    = 15;  // Any output voltage flag
  localparam int SUM_VOUT_OV_BIT = 5;   // Output overvoltage
  localparam int SUM_OUTPUT_OVERCURRENT_SUMMARY_BIT = 4;   // Output overcurrent
  localparam int SUM_INPUT_UNDERVOLT_SUMMARY_BIT  = 3;   // Input below lockout
  localparam int SUM_TEMP_BIT    = 2;   // Over-temperature
  localparam int SUM_CML_BIT     = 1;   // Communication, memory, logic
  localparam int SUM_OTHER_BIT   = 0;   // Anything else

  // ----------------------------------------------------------------
  // Transaction carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PVS_PROT_BYTE  = 2'b00,  // Read Byte / Write Byte
    PVS_PROT_WORD  = 2'b01,  // Read Word / Write Word
    PVS_PROT_OTHER = 2'b10   // Any other protocol
  } pvs_prot_t;

  typedef struct packed {
    logic       valid;  // One-cycle request strobe
    logic       write;  // 1 write, 0 read
    pvs_prot_t  prot;   // Protocol of the transaction
    logic [7:0] cmd;    // Command code
    logic [15:0] data;  // Write data, byte in low bits
  } pvs_req_t;

  typedef struct packed {
    logic        done;    // One-cycle completion strobe
    logic        reject;  // Transaction was invalid
    logic [15:0] data;    // Read data, byte in low bits
  } pvs_rsp_t;

  typedef struct packed {
    logic ovf;    // Overvoltage detected
    logic uvf;    // Undervoltage detected
    logic limit;  // Out-of-limits programming attempt
  } pvs_fault_t;

  typedef struct packed {
    logic temp;   // Latched temperature detail flag
    logic oc;     // Latched output overcurrent detail flag
    logic other;  // Other latched detail flag, e.g. overcurrent warning
  } pvs_detail_t;

endpackage

// ---- pvs_vout_status_assertions.sv ----
`timescale 1ns/1ps
module pvs_vout_status_assertions #(
  parameter int CH_NUM = pvs_pkg::CH_NUM  // Number of paged channels
) (
  input wire logic                              clock_i,           // System clock
  input wire logic                              rst_b_i,           // Async reset, low
  input wire pvs_pkg::pvs_req_t                 req_i,             // Decoded command
  input wire pvs_pkg::pvs_rsp_t                 rsp_o,             // Command answer
  input wire pvs_pkg::pvs_fault_t [CH_NUM-1:0]  fault_i,           // Output detectors
  input wire pvs_pkg::pvs_detail_t [CH_NUM-1:0] detail_i,          // Other status bytes
  input wire logic                              input_undervolt_i, // Shared lockout flag
  input wire logic                              cml_detail_i,      // Shared flag
  input wire logic [7:0]                        page_o,            // Current selector
  input wire logic [CH_NUM-1:0][7:0]            vout_status_o,     // Status bytes
  input wire logic [CH_NUM-1:0][15:0]           summary_o          // Summary words
);
  // ----------------------------------------------------------------
  // Shorthands
  // ----------------------------------------------------------------
  wire logic vout_wr  = req_i.valid && req_i.write && (req_i.cmd == pvs_pkg::CMD_VOUT);
  wire logic byte_rd  = req_i.valid && !req_i.write && (req_i.prot == pvs_pkg::PVS_PROT_BYTE);
  wire logic sum_wr   = req_i.valid && req_i.write && (req_i.cmd == pvs_pkg::CMD_SUMMARY);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Summary word bits, refused summary writes and broadcast reads
  // ----------------------------------------------------------------
  a_sum_input_uv: assert property (
    summary_o[0][3] == input_undervolt_i && summary_o[1][3] == input_undervolt_i)
    else $error("summary lockout bit wrong");
  a_sum_temp_mirror: assert property (
    summary_o[1][2] == detail_i[1].temp)
    else $error("summary temperature bit wrong");
  a_sum_cml_mirror: assert property (
    summary_o[0][1] == cml_detail_i)
    else $error("summary comm bit wrong");
  a_sum_other_bit: assert property (
    summary_o[0][0] == (vout_status_o[0][4] | detail_i[0].other))
    else $error("summary other bit wrong");
  a_sum_vout_derive: assert property (
    summary_o[0][15] == (|vout_status_o[0]) && summary_o[0][5] == vout_status_o[0][7])
    else $error("summary voltage bits wrong");
  // A rejected write must not disturb any flag, so faults are kept quiet here
  a_sum_write_reject: assert property (
    sum_wr && fault_i == '0 |=>
      rsp_o.done && rsp_o.reject && vout_status_o == $past(vout_status_o))
    else $error("summary write not refused");
  a_page_all_reads: assert property (
    byte_rd && req_i.cmd == pvs_pkg::CMD_VOUT && page_o == pvs_pkg::PAGE_ALL |=>
      rsp_o.data == {8'h00, $past(vout_status_o[0])})
    else $error("all-page read not channel A");

  // ----------------------------------------------------------------
  // Voltage flags latch, hold and clear
  // ----------------------------------------------------------------
  a_ovf_latch_next: assert property (
    fault_i[0].ovf |=> vout_status_o[0][7])
    else $error("overvoltage flag not set");
  a_uvf_latch_next: assert property (
    fault_i[1].uvf |=> vout_status_o[1][4])
    else $error("undervoltage flag not set");
  a_limit_latch_next: assert property (
    fault_i[0].limit |=> vout_status_o[0][3])
    else $error("limit flag not set");
  a_unused_bits_zero: assert property (
    ((vout_status_o[0] | vout_status_o[1]) & ~pvs_pkg::VOUT_SUP_MASK) == 8'h00)
    else $error("unused voltage bit set");
  a_flag_held_sticky: assert property (
    vout_status_o[0][7] && !(vout_wr && req_i.data[7]) |=> vout_status_o[0][7])
    else $error("overvoltage flag lost");
  a_clear_drops_both: assert property (
    vout_wr && req_i.data[7] && req_i.prot == pvs_pkg::PVS_PROT_BYTE &&
      page_o == pvs_pkg::PAGE_A && !fault_i[0].ovf |=>
      !vout_status_o[0][7] && !summary_o[0][5])
    else $error("overvoltage clear failed");

  // ----------------------------------------------------------------
  // Scenario coverage
  // ----------------------------------------------------------------
  c_reject_seen: cover property (rsp_o.done && rsp_o.reject);
  c_all_page_write: cover property (vout_wr && page_o == pvs_pkg::PAGE_ALL);
  c_ovf_cleared: cover property ($fell(vout_status_o[0][7]));
endmodule // pvs_vout_status_assertions

bind pvs_vout_status pvs_vout_status_assertions #(.CH_NUM(CH_NUM)) u_pvs_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req_i), .rsp_o(rsp_o), .fault_i(fault_i),
  .detail_i(detail_i), .input_undervolt_i(input_undervolt_i), .cml_detail_i(cml_detail_i),
  .page_o(page_o), .vout_status_o(vout_status_o), .summary_o(summary_o));

// ---- pvs_host_model.sv ----
`timescale 1ns/1ps
module pvs_host_model (
  input  wire logic              clock_i, // System clock
  output pvs_pkg::pvs_req_t      req_o,   // Request to the block
  input  wire pvs_pkg::pvs_rsp_t rsp_i    // Answer from the block
);
  initial req_o = '0;  // Idle until the first transfer
  // One transaction: strobe for one cycle, take the answer in the cycle after
  task automatic xfer(input logic w, input logic [1:0] p, input logic [7:0] c,
                      input logic [15:0] d, output pvs_pkg::pvs_rsp_t r);
    @(posedge clock_i);
    req_o <= '{1'b1, w, pvs_pkg::pvs_prot_t'(p), c, d};
    @(posedge clock_i);
    req_o.valid <= 1'b0;
    req_o.data  <= ~d;  // Released data is scrambled, never left stale
    #1 r = rsp_i;
  endtask
endmodule // pvs_host_model

// ---- pmbus_vout_status_reporting_tb.sv ----
`timescale 1ns/1ps
module pmbus_vout_status_reporting_tb;
  typedef struct packed {
    logic w; logic [1:0] p; logic [7:0] c; logic [15:0] d; logic rj; logic [15:0] q;
  } pvs_row_t;
  logic                            clock_i = 1'b0;  // 200 MHz clock
  logic                            rst_b_i;         // Async reset, low
  pvs_pkg::pvs_req_t               req;             // Host request
  pvs_pkg::pvs_rsp_t               rsp, r;          // Answer and captured answer
  pvs_pkg::pvs_fault_t [1:0]       fault;           // Detector stimulus
  pvs_pkg::pvs_detail_t [1:0]      detail;          // Other status bytes
  logic                            input_undervolt, cml_detail;
  logic [7:0]                      page;
  logic [1:0][7:0]                 vout_status;
  logic [1:0][15:0]                summary;
  int                              bad_count = 0, check_count = 0;
  // Write, prot, cmd, data, reject, read data; flags A=88h, B=10h at start
  pvs_row_t rows [21] = '{
    '{0,2'h0,8'h7a,16'h0000,0,16'h0088}, '{1,2'h0,8'h00,16'h0001,0,16'h0000},
    '{0,2'h0,8'h7a,16'h0000,0,16'h0010}, '{0,2'h1,8'h79,16'h0000,0,16'h800f},
    '{1,2'h1,8'h79,16'hffff,1,16'h0000}, '{1,2'h1,8'h7a,16'h0010,1,16'h0000},
    '{0,2'h0,8'h7a,16'h0000,0,16'h0010}, '{1,2'h0,8'h7a,16'h0010,0,16'h0000},
    '{0,2'h1,8'h79,16'h0000,0,16'h000e}, '{1,2'h0,8'h00,16'h00ff,0,16'h0000},
    '{0,2'h0,8'h7a,16'h0000,0,16'h0088}, '{1,2'h0,8'h7a,16'h0008,0,16'h0000},
    '{0,2'h0,8'h7a,16'h0000,0,16'h0080}, '{1,2'h0,8'h00,16'h0005,1,16'h0000},
    '{0,2'h0,8'h79,16'h0000,1,16'h0000}, '{0,2'h0,8'h55,16'h0000,1,16'h0000},
    '{1,2'h0,8'h7a,16'h0000,0,16'h0000}, '{0,2'h0,8'h7a,16'h0000,0,16'h0080},
    '{1,2'h0,8'h00,16'h0000,0,16'h0000}, '{1,2'h0,8'h7a,16'h0080,0,16'h0000},
    '{0,2'h1,8'h79,16'h0000,0,16'h000a}};

  always #2.5 clock_i = ~clock_i;  // Half period of 5 ns clock

  pvs_vout_status dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .rsp_o(rsp),
    .fault_i(fault), .detail_i(detail), .input_undervolt_i(input_undervolt),
    .cml_detail_i(cml_detail), .page_o(page), .vout_status_o(vout_status), .summary_o(summary));
  pvs_host_model u_host (.clock_i(clock_i), .req_o(req), .rsp_i(rsp));

  // Count every comparison, report each mismatch at once
  task automatic check_val(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    fault = '0;
    detail = '0;
    input_undervolt = 1'b0;
    cml_detail = 1'b0;
    repeat (10) @(posedge clock_i);
    #1 check_val("reset vout", 16'h0000, vout_status);
    check_val("reset page", 16'h0000, {8'h00, page});
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    fault[0] <= 3'b101;  // Overvoltage and limit on A
    fault[1] <= 3'b010;  // Undervoltage on B
    input_undervolt <= 1'b1;
    cml_detail <= 1'b1;
    detail[1].temp <= 1'b1;
    @(posedge clock_i);
    fault <= '0;
    for (int i = 0; i < 21; i++) begin
      u_host.xfer(rows[i].w, rows[i].p, rows[i].c, rows[i].d, r);
      check_val("done", 16'h0001, {15'h0000, r.done});
      check_val("reject", {15'h0000, rows[i].rj}, {15'h0000, r.reject});
      check_val("data", rows[i].q, r.data);
    end
    // Clear attempt while the fault persists must leave the flag set
    @(posedge clock_i);
    fault[0].ovf <= 1'b1;
    detail[0] <= 3'b011;  // Overcurrent and other on A
    u_host.xfer(1'b1, 2'h0, 8'h7a, 16'h0080, r);
    u_host.xfer(1'b0, 2'h0, 8'h7a, 16'h0000, r);
    check_val("persist", 16'h0080, r.data);
    u_host.xfer(1'b0, 2'h1, 8'h79, 16'h0000, r);
    check_val("summary", 16'h803b, r.data);
    check_val("summary pin", 16'h803b, summary[0]);
    check_val("vout pin", 16'h0080, {8'h00, vout_status[0]});
    check_val("page pin", 16'h0000, {8'h00, page});
    complete_run();
  end

  // Watchdog: the whole sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clock_i);
    bad_count++;
    complete_run();
  end
endmodule // pmbus_vout_status_reporting_tb
